/* File: hdl/asa_alarm_status.sv */
`timescale 1ns/1ps
`include "asa_defs.svh"
module asa_alarm_status
  import asa_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic SOFT_RESET,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [9:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic SERIAL_LINK_ENABLE,
  input wire asa_enc_e LINK_ENCODING,
  input wire logic LINK_IN_DATA_STATE,
  input wire logic LINK_STARTUP,
  input wire logic LINK_REALIGN,
  input wire logic [15:0] LANE_ACTIVE,
  input wire logic [15:0] LANE_FIFO_ERROR,
  input wire logic PLL_LOCKED,
  input wire logic SYSREF_REALIGNED,
  input wire logic NCO_SYNC_EVENT,
  input wire logic NCO_PHASE_MISMATCH,
  input wire logic DIVIDER_MISMATCH,
  input wire logic CAL_STATUS_SEL_ALARM,
  input wire logic CAL_STATUS_OTHER,
  output logic CALIBRATION_STATUS_PIN
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Condition inputs come from other clock domains; each passes two stages.
  localparam int NSYNC = 42;
  // Bit positions of each input inside the synchroniser vector
  localparam int SY_LINK_EN = 41;
  localparam int SY_ENC = 40;
  localparam int SY_IN_DATA = 39;
  localparam int SY_STARTUP = 38;
  localparam int SY_REALIGN = 37;
  localparam int SY_LANE_ACT = 21;
  localparam int SY_LANE_ERR = 5;
  localparam int SY_PLL = 4;
  localparam int SY_SYSREF = 3;
  localparam int SY_NCO_SYNC = 2;
  localparam int SY_NCO_MIS = 1;
  localparam int SY_DIV = 0;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] raw_in;

  assign raw_in = {SERIAL_LINK_ENABLE,
                   LINK_ENCODING,
                   LINK_IN_DATA_STATE,
                   LINK_STARTUP,
                   LINK_REALIGN,
                   LANE_ACTIVE,
                   LANE_FIFO_ERROR,
                   PLL_LOCKED,
                   SYSREF_REALIGNED,
                   NCO_SYNC_EVENT,
                   NCO_PHASE_MISMATCH,
                   DIVIDER_MISMATCH};

  // Bits are synchronised one by one; lanes may skew by a cycle, which is
  // harmless because every lane is flagged on its own.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  logic link_en;
  logic enc_64b;
  logic in_data;
  logic startup;
  logic realign;
  logic [15:0] lane_act;
  logic [15:0] lane_err;
  logic pll_locked;
  logic sysref_re;
  logic nco_sync;
  logic nco_mis;
  logic div_mis;

  // Only the second stage is read past this point
  assign link_en = sync2_reg[SY_LINK_EN];
  assign enc_64b = sync2_reg[SY_ENC];
  assign in_data = sync2_reg[SY_IN_DATA];
  assign startup = sync2_reg[SY_STARTUP];
  assign realign = sync2_reg[SY_REALIGN];
  assign lane_act = sync2_reg[SY_LANE_ACT+15:SY_LANE_ACT];
  assign lane_err = sync2_reg[SY_LANE_ERR+15:SY_LANE_ERR];
  // Reads as unlocked just after reset; the flags start set anyway
  assign pll_locked = sync2_reg[SY_PLL];
  assign sysref_re = sync2_reg[SY_SYSREF];
  assign nco_sync = sync2_reg[SY_NCO_SYNC];
  assign nco_mis = sync2_reg[SY_NCO_MIS];
  assign div_mis = sync2_reg[SY_DIV];

  // ****************************************
  // Register decode
  // ****************************************
  function automatic logic hit(input logic [9:0] a, input logic [9:0] ref_a);
    hit = (a == ref_a);
  endfunction

  logic wr_flags;
  logic wr_mask;
  logic wr_lane_lo;
  logic wr_lane_hi;

  assign wr_flags = REG_WR && hit(REG_ADDR, `ASA_ADDR_FLAGS);
  assign wr_mask = REG_WR && hit(REG_ADDR, `ASA_ADDR_MASK);
  assign wr_lane_lo = REG_WR && hit(REG_ADDR, `ASA_ADDR_LANE_LO);
  assign wr_lane_hi = REG_WR && hit(REG_ADDR, `ASA_ADDR_LANE_HI);

  // ****************************************
  // Alarm conditions
  // ****************************************
  // Flag contents are undefined while the link is disabled; software must
  // clear them after enabling the link.
  // NCO flag forced set, link condition held clear while link disabled
  asa_flags_t cond;
  logic [15:0] lane_hit;

  assign lane_hit = lane_err & lane_act;

  always_comb
  begin
    cond = '0;
    cond[`ASA_BIT_FIFO] = |lane_hit;
    cond[`ASA_BIT_PLL] = !pll_locked;
    if (enc_64b)
      cond[`ASA_BIT_LINK] = link_en && (startup || realign);
    else
      cond[`ASA_BIT_LINK] = link_en && !in_data;
    cond[`ASA_BIT_REALIGN] = sysref_re;
    cond[`ASA_BIT_NCO] = !link_en || nco_sync || nco_mis;
    cond[`ASA_BIT_CLK] = div_mis;
  end

  // ****************************************
  // Sticky flags
  // ****************************************
  asa_flags_t flags_reg;
  asa_flags_t flags_next;
  asa_flags_t mask_reg;
  asa_lanes_t lane_reg;
  asa_lanes_t lane_next;
  logic fifo_clear;

  assign fifo_clear = wr_flags && REG_WDATA[`ASA_BIT_FIFO];

  asa_flags_t clr_bits;

  // Reserved bits 7:6 of the write data are dropped here
  assign clr_bits = wr_flags ? REG_WDATA[5:0] : 6'h00;

  assign flags_next = (flags_reg & ~clr_bits) | cond;

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      flags_reg <= `ASA_FLAGS_RST;
    else if (SOFT_RESET)
      flags_reg <= `ASA_FLAGS_RST;
    else
      flags_reg <= flags_next;
  end

  // ****************************************
  // Per-lane FIFO error vector
  // ****************************************
  // Per-lane vector: own write-one-clear, also cleared via the FIFO flag.
  // A lane whose error persists trips again in the same cycle.
  always_comb
  begin
    lane_next = lane_reg;
    if (wr_lane_lo)
      lane_next[7:0] = lane_next[7:0] & ~REG_WDATA;
    if (wr_lane_hi)
      lane_next[15:8] = lane_next[15:8] & ~REG_WDATA;
    if (fifo_clear)
      lane_next = '0;
    lane_next = lane_next | lane_hit;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      lane_reg <= `ASA_LANE_RST;
    else if (SOFT_RESET)
      lane_reg <= `ASA_LANE_RST;
    else
      lane_reg <= lane_next;
  end

  // ****************************************
  // Mask register
  // ****************************************
  // Masks only gate the summary; flags keep latching while masked.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      mask_reg <= `ASA_MASK_RST;
    else if (SOFT_RESET)
      mask_reg <= `ASA_MASK_RST;
    else if (wr_mask)
      mask_reg <= REG_WDATA[5:0];
  end

  // ****************************************
  // Summary and pin
  // ****************************************
  logic summary;

  assign summary = |(flags_reg & ~mask_reg);

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      CALIBRATION_STATUS_PIN <= 1'b0;
    else if (CAL_STATUS_SEL_ALARM)
      CALIBRATION_STATUS_PIN <= summary;
    else
      CALIBRATION_STATUS_PIN <= CAL_STATUS_OTHER;
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] rd_mux;

  always_comb
  begin
    case (REG_ADDR)
      `ASA_ADDR_SUMMARY: rd_mux = {7'h00, summary};
      `ASA_ADDR_FLAGS: rd_mux = {2'h0, flags_reg};
      `ASA_ADDR_MASK: rd_mux = {2'h0, mask_reg};
      `ASA_ADDR_LANE_LO: rd_mux = lane_reg[7:0];
      `ASA_ADDR_LANE_HI: rd_mux = lane_reg[15:8];
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data is registered: valid the cycle after REG_RD.
  // Holding between reads lets software sample it late.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      REG_RDATA <= 8'h00;
    else if (REG_RD)
      REG_RDATA <= rd_mux;
  end

endmodule

/* File: hdl/asa_defs.svh */
`ifndef ASA_DEFS_SVH
`define ASA_DEFS_SVH

// Register byte addresses on the register port
`define ASA_ADDR_SUMMARY 10'h2c0
`define ASA_ADDR_FLAGS 10'h2c1
`define ASA_ADDR_MASK 10'h2c2
`define ASA_ADDR_LANE_LO 10'h2c4
`define ASA_ADDR_LANE_HI 10'h2c5

// Field positions in the flag and mask registers
`define ASA_BIT_FIFO 5
`define ASA_BIT_PLL 4
`define ASA_BIT_LINK 3
`define ASA_BIT_REALIGN 2
`define ASA_BIT_NCO 1
`define ASA_BIT_CLK 0

// Reset values
`define ASA_FLAGS_RST 6'h3f
`define ASA_MASK_RST 6'h3f
`define ASA_LANE_RST 16'hffff

`endif

/* File: hdl/asa_pkg.sv */
package asa_pkg;
  typedef logic [5:0] asa_flags_t;
  typedef logic [15:0] asa_lanes_t;
  typedef enum logic {ASA_ENC_8B10B, ASA_ENC_64B66B} asa_enc_e;
endpackage

/* File: verification/asa_checker.sv */
`timescale 1ns/1ps
// ****
// Port checks
// ****
module asa_checker (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic REG_RD,
  input wire logic [9:0] REG_ADDR,
  input wire logic [7:0] REG_RDATA,
  input wire logic SERIAL_LINK_ENABLE,
  input wire logic PLL_LOCKED,
  input wire logic SYSREF_REALIGNED,
  input wire logic DIVIDER_MISMATCH,
  input wire logic CAL_STATUS_SEL_ALARM,
  input wire logic CAL_STATUS_OTHER,
  input wire logic CALIBRATION_STATUS_PIN
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  // A condition reaches the flag two edges after it is sampled
  sequence rd_flags;
    REG_RD && REG_ADDR == 10'h2c1;
  endsequence
  pin_other_a: assert property (!CAL_STATUS_SEL_ALARM |=>
    CALIBRATION_STATUS_PIN == $past(CAL_STATUS_OTHER)) else $error("pin");
  pin_sum_a: assert property (CAL_STATUS_SEL_ALARM && REG_RD &&
    REG_ADDR == 10'h2c0 |=> CALIBRATION_STATUS_PIN == REG_RDATA[0])
    else $error("sum");
  sum_upper_a: assert property (REG_RD && REG_ADDR == 10'h2c0 |=>
    REG_RDATA[7:1] == 7'h0) else $error("upper");
  unmapped_a: assert property (REG_RD && REG_ADDR == 10'h3ff |=>
    REG_RDATA == 8'h0) else $error("map");
  rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("hold");
  pll_flag_a: assert property (
    (!PLL_LOCKED && SERIAL_LINK_ENABLE)[*4] ##0 rd_flags |=> REG_RDATA[4])
    else $error("pll");
  realign_flag_a: assert property (
    SERIAL_LINK_ENABLE && SYSREF_REALIGNED ##3 rd_flags |=> REG_RDATA[2])
    else $error("sysref");
  div_flag_a: assert property (DIVIDER_MISMATCH[*4] ##0 rd_flags |=>
    REG_RDATA[0]) else $error("clk");
endmodule

bind asa_alarm_status asa_checker asa_checker_inst (.*);

/* File: verification/asa_alarm_status_tb.sv */
`timescale 1ns/1ps
// ****
// Alarm bench
// ****
module asa_alarm_status_tb import asa_pkg::*;;
  logic CLK = 1'h0, ARST_N = 1'h0, SOFT_RESET = 1'h0, REG_WR = 1'h0;
  logic REG_RD = 1'h0, rd_seen = 1'h0, CAL_STATUS_SEL_ALARM = 1'h0;
  logic [9:0] REG_ADDR = 10'h0;
  logic [7:0] REG_WDATA = 8'h0, REG_RDATA, q[$];
  logic [5:0] c = 6'h0;
  logic [15:0] s = 16'h2e72;
  logic CALIBRATION_STATUS_PIN;
  wire SERIAL_LINK_ENABLE = 1'h1;
  logic LINK_STARTUP = 1'h0, LINK_REALIGN = 1'h0;
  wire CAL_STATUS_OTHER = s[0], PLL_LOCKED = !c[4];
  wire LINK_IN_DATA_STATE = !c[3], SYSREF_REALIGNED = c[2];
  wire NCO_SYNC_EVENT = c[1] & s[0], NCO_PHASE_MISMATCH = c[1] & !s[0];
  wire DIVIDER_MISMATCH = c[0];
  wire [15:0] LANE_ACTIVE = 16'hffff, LANE_FIFO_ERROR = {12'h0, c[5], 3'h0};
  asa_enc_e LINK_ENCODING = ASA_ENC_8B10B;
  int fails = 0, checked = 0;
  asa_alarm_status asa_alarm_status_inst (.*);
  initial
  begin
    forever #12.5 CLK = !CLK;
  end
  // Read data lands on the taking edge, so look half a cycle later
  always @(posedge CLK) rd_seen <= REG_RD;
  always @(negedge CLK)
    if (rd_seen)
      check(REG_RDATA, q.pop_front());
  task automatic check(input logic [7:0] v, input logic [7:0] e);
    checked++;
    if (v !== e)
    begin
      fails++;
      $display("Error %0t %h %h", $time, v, e);
    end
  endtask
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(negedge CLK);
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {w, !w, a, d};
    if (!w)
      q.push_back(d);
    @(negedge CLK);
    {REG_WR, REG_RD} = 2'h0;
  endtask
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic conclude;
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge CLK);
    ARST_N = 1'h1;
    acc(0, 10'h2c1, 8'h3f);
    acc(0, 10'h2c2, 8'h3f);
    acc(0, 10'h2c0, 8'h0);
    acc(1, 10'h2c0, 8'hff);
    acc(1, 10'h2c1, 8'hff);
    acc(0, 10'h2c1, 8'h0);
    acc(0, 10'h3ff, 8'h0);
    for (int i = 5; i >= 0; i--)
    begin
      c = 6'h1 << i;
      s = nx(s);
      repeat (4) @(negedge CLK);
      // Clearing under a live condition must not lose the alarm
      acc(1, 10'h2c1, 8'h1 << i);
      acc(0, 10'h2c1, 8'h1 << i);
      acc(0, 10'h2c4, {4'h0, c[5], 3'h0});
      c = 6'h0;
      repeat (4) @(negedge CLK);
      acc(1, 10'h2c1, 8'h3f ^ (8'h1 << i));
      acc(0, 10'h2c1, 8'h1 << i);
      acc(1, 10'h2c1, 8'h1 << i);
      acc(0, 10'h2c4, 8'h0);
    end
    LINK_ENCODING = ASA_ENC_64B66B;
    for (int k = 0; k < 2; k++)
    begin
      {LINK_STARTUP, LINK_REALIGN} = (k == 0) ? 2'h2 : 2'h1;
      @(negedge CLK);
      {LINK_STARTUP, LINK_REALIGN} = 2'h0;
      repeat (4) @(negedge CLK);
      acc(0, 10'h2c1, 8'h08);
      acc(1, 10'h2c1, 8'h08);
      acc(0, 10'h2c1, 8'h00);
    end
    LINK_ENCODING = ASA_ENC_8B10B;
    @(negedge CLK);
    SOFT_RESET = 1'h1;
    @(negedge CLK);
    SOFT_RESET = 1'h0;
    CAL_STATUS_SEL_ALARM = 1'h1;
    acc(0, 10'h2c1, 8'h3f);
    acc(0, 10'h2c0, 8'h0);
    repeat (4)
    begin
      s = nx(s);
      acc(1, 10'h2c2, {2'h0, s[5:0]});
      acc(0, 10'h2c0, {7'h0, s[5:0] != 6'h3f});
      check({7'h0, CALIBRATION_STATUS_PIN}, {7'h0, s[5:0] != 6'h3f});
    end
    @(negedge CLK);
    conclude;
  end
endmodule
